/* File: verilog/mts_engine.sv */
// What this block does
// - Verify mismatch sets per-channel bad flag, write-one clears
// - Bits 5:4 pick zero, random or inverted pattern
// - Pass end sets scrub complete, write-one clears
// - Enable bit runs mode chosen by bits 2:1
// - Mode 00 writes pattern randomly over test rank
// - Mode 10 patrols all memory, one access every 16k cycles
// - Mode 11 reads and checks randomly over rank
// - Clearing enable resets patrol scrub counters
// - Enable bit excluded from configuration save-restore
// - Throttled read or write sets sticky flags
// - Bit 20 picks activate throttle window policy
// - Single rank at threshold starts spare fail-over
// - Bit 14 enables demand scrub of corrected data
// - Bits 13..11 choose scrub and sparing algorithms
// - Bit 8 restricts fast modes to recorded address
// - Thermal cap limits bandwidth per 100us window
// - Wipe writes zeros to failing module during copy
// - Spare rank field frozen during copy or wipe
// - Bits 2:0 select rank for fast modes
`include "mts_consts.svh"

module mts_engine
    import mts_pkg::*;
#(
    parameter int ADDR_W     = 20,
    parameter int PATROL_CYC = `MTS_PATROL_CYC,
    parameter int CAP_CYC    = `MTS_CAP_CYC
) (
    input  wire logic                         CORE_CLK,
    input  wire logic                         RST,
    input  wire logic [`MTS_ADDR_W-1:0]       WB_ADR_I,
    input  wire logic [31:0]                  WB_DAT_I,
    output logic      [31:0]                  WB_DAT_O,
    input  wire logic                         WB_WE_I,
    input  wire logic [3:0]                   WB_SEL_I,
    input  wire logic                         WB_STB_I,
    input  wire logic                         WB_CYC_I,
    output logic                              WB_ACK_O,
    output logic                              WB_ERR_O,
    output mts_pkg::mts_mem_req_t             MEM_REQ,
    input  wire logic                         MEM_READY,
    input  wire mts_pkg::mts_mem_rsp_t        MEM_RSP,
    input  wire logic                         MEM_WR_FLUSHED,
    input  wire logic [31:0]                  RECORDED_ERROR_ADDR,
    input  wire logic                         RD_THROTTLED,
    input  wire logic                         WR_THROTTLED,
    input  wire logic                         ACTIVATE_REQ,
    input  wire logic                         FIRST_GEN_DDR_SELECT,
    input  wire logic                         SPARING_ENABLE,
    input  wire logic [7:0][3:0]              RANK_ERROR_COUNT,
    input  wire logic                         SPARE_COPY_BUSY,
    input  wire logic                         CONFIG_SAVE_RESTORE,
    output logic                              ACTIVATE_GRANT,
    output logic                              THERMAL_GRANT,
    output logic                              SPARE_START,
    output logic      [2:0]                   SPARE_FAILED_RANK,
    output logic                              WIPE_ZEROS,
    output logic                              DEMAND_SCRUB_ENABLE,
    output logic      [2:0]                   SCRUB_ALGORITHMS
);
    import mts_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one-cycle ack, ack drops the cycle after it is given.

    logic [1:0]  result_r;
    logic [5:0]  ctrl_r;
    logic [31:0] mcs_r;
    logic        req_ok;
    logic        wr_res;
    logic        wr_ctl;
    logic        wr_mcs;
    logic [7:0]  idx;
    logic        mapped;

    assign idx    = WB_ADR_I[9:2];
    assign mapped = (idx == `MTS_IDX_RESULT) || (idx == `MTS_IDX_CTRL) || (idx == `MTS_IDX_MCS);
    assign req_ok = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
    assign wr_res = req_ok && WB_WE_I && (idx == `MTS_IDX_RESULT) && WB_SEL_I[0];
    assign wr_ctl = req_ok && WB_WE_I && (idx == `MTS_IDX_CTRL) && WB_SEL_I[0];
    assign wr_mcs = req_ok && WB_WE_I && (idx == `MTS_IDX_MCS);

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_ERR_O <= 1'b0;
        end else begin
            WB_ACK_O <= req_ok && mapped;
            WB_ERR_O <= req_ok && !mapped;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            WB_DAT_O <= 32'h0;
        end else if (req_ok && !WB_WE_I) begin
            case (idx)
                `MTS_IDX_RESULT: WB_DAT_O <= {30'h0, result_r};
                `MTS_IDX_CTRL:   WB_DAT_O <= {26'h0, ctrl_r};
                `MTS_IDX_MCS:    WB_DAT_O <= mcs_r;
                default:         WB_DAT_O <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Engine state.

    typedef enum {ST_IDLE, ST_RUN, ST_FLUSH, ST_STOP} st_t;
    st_t st_r;

    logic              en;
    mts_mode_t         mode;
    mts_pat_t          pat;
    logic              reserved_sel;
    logic [ADDR_W-1:0] cnt_r;
    logic [ADDR_W-1:0] lfsr_r;
    logic [63:0]       rnd_r;
    logic [14:0]       patrol_tmr_r;
    logic              patrol_tick;
    logic              single;
    logic              issue;
    logic              last;
    logic              pass_done;
    logic [1:0]        bad_set;

    assign en           = ctrl_r[`MTS_CTL_EN];
    assign mode         = mts_mode_t'(ctrl_r[`MTS_CTL_MODE_HI:`MTS_CTL_MODE_LO]);
    assign pat          = mts_pat_t'(ctrl_r[`MTS_CTL_PAT_HI:`MTS_CTL_PAT_LO]);
    assign single       = mcs_r[`MTS_MC_SINGLE];
    // A reserved mode, or a reserved pattern outside patrol, keeps the engine in idle, so neither pass flag can move.
    assign reserved_sel = (mode == MTS_MODE_RSVD) || (mode != MTS_MODE_PATROL && pat == MTS_PAT_RSVD);
    assign patrol_tick  = (patrol_tmr_r == 15'(PATROL_CYC - 1));
    assign issue        = (st_r == ST_RUN) && MEM_READY && THERMAL_GRANT
                          && ((mode != MTS_MODE_PATROL) || patrol_tick);
    assign last         = single ? 1'b1 : (cnt_r == {ADDR_W{1'b1}});
    assign pass_done    = (st_r == ST_FLUSH) && MEM_WR_FLUSHED;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_r <= ST_IDLE;
        end else if (!en) begin
            st_r <= ST_IDLE;
        end else begin
            case (st_r)
                ST_IDLE:  st_r <= reserved_sel ? ST_IDLE : ST_RUN;
                ST_RUN:   st_r <= (issue && last) ? ST_FLUSH : ST_RUN;
                // Patrol walks memory forever; fast modes stop after one pass.
                ST_FLUSH: st_r <= !MEM_WR_FLUSHED ? ST_FLUSH :
                                  (mode == MTS_MODE_PATROL ? ST_RUN : ST_STOP);
                ST_STOP:  st_r <= ST_STOP;
                default:  st_r <= ST_IDLE;
            endcase
        end
    end

    // Clearing enable zeroes the walk and patrol timers.
    always_ff @(posedge CORE_CLK) begin
        if (RST || !en) begin
            cnt_r        <= '0;
            patrol_tmr_r <= 15'h0;
        end else begin
            if (issue) begin
                cnt_r <= cnt_r + 1'b1;
            end
            if (st_r == ST_RUN && mode == MTS_MODE_PATROL) begin
                patrol_tmr_r <= patrol_tick ? 15'h0 : patrol_tmr_r + 15'h1;
            end
        end
    end

    // The LFSR holds still during a pass, so cnt ^ lfsr visits every address once.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            lfsr_r <= {{(ADDR_W-1){1'b0}}, 1'b1};
            rnd_r  <= 64'h1;
        end else begin
            if (st_r != ST_RUN) begin
                lfsr_r <= {lfsr_r[ADDR_W-2:0], lfsr_r[ADDR_W-1] ^ lfsr_r[ADDR_W-4]};
            end
            rnd_r <= {rnd_r[62:0], rnd_r[63] ^ rnd_r[62] ^ rnd_r[60] ^ rnd_r[59]};
        end
    end

    // The whole line carries one pattern word.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            MEM_REQ <= '0;
        end else begin
            MEM_REQ.valid <= issue;
            MEM_REQ.write <= (mode == MTS_MODE_FWRITE);
            MEM_REQ.rank  <= mcs_r[`MTS_MC_RANK_HI:`MTS_MC_RANK_LO];
            MEM_REQ.addr  <= single ? RECORDED_ERROR_ADDR :
                             32'(mode == MTS_MODE_PATROL ? cnt_r : (cnt_r ^ lfsr_r));
            case (pat)
                MTS_PAT_ZERO: MEM_REQ.data <= 64'h0;
                MTS_PAT_RAND: MEM_REQ.data <= rnd_r;
                MTS_PAT_INV:  MEM_REQ.data <= ~rnd_r;
                default:      MEM_REQ.data <= 64'h0;
            endcase
        end
    end

    assign bad_set = (MEM_RSP.valid && mode == MTS_MODE_FVERIFY && en) ? MEM_RSP.mismatch : 2'b00;

    ////////////////////////////////////////////////////////////////////////////
    // Registers; hardware sets win over write-one clears.

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            result_r <= 2'b00;
        end else begin
            result_r <= (result_r & ~(wr_res ? WB_DAT_I[1:0] : 2'b00)) | bad_set;
        end
    end

    // The enable bit has no save copy; a restore only holds it off.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl_r <= 6'h0;
        end else begin
            if (wr_ctl) begin
                ctrl_r[`MTS_CTL_PAT_HI:`MTS_CTL_PAT_LO]   <= WB_DAT_I[`MTS_CTL_PAT_HI:`MTS_CTL_PAT_LO];
                ctrl_r[`MTS_CTL_MODE_HI:`MTS_CTL_MODE_LO] <= WB_DAT_I[`MTS_CTL_MODE_HI:`MTS_CTL_MODE_LO];
                ctrl_r[`MTS_CTL_EN] <= WB_DAT_I[`MTS_CTL_EN] && !CONFIG_SAVE_RESTORE;
            end
            ctrl_r[`MTS_CTL_DONE] <= pass_done ||
                (ctrl_r[`MTS_CTL_DONE] && !(wr_ctl && WB_DAT_I[`MTS_CTL_DONE]));
        end
    end

    logic       copy_busy;
    logic [1:0] thr_set;

    assign copy_busy = SPARE_COPY_BUSY;
    assign thr_set   = {WR_THROTTLED, RD_THROTTLED};

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mcs_r <= 32'h0;
        end else begin
            if (wr_mcs) begin
                for (int b = 0; b < 4; b++) begin
                    if (WB_SEL_I[b]) begin
                        mcs_r[b*8 +: 8] <= WB_DAT_I[b*8 +: 8] & 8'(`MTS_MC_RW_MASK >> (b*8));
                    end
                end
                if (copy_busy) begin
                    mcs_r[`MTS_MC_SPARE_HI:`MTS_MC_SPARE_LO] <= mcs_r[`MTS_MC_SPARE_HI:`MTS_MC_SPARE_LO];
                end
            end
            mcs_r[`MTS_MC_WRTHR:`MTS_MC_RDTHR] <= thr_set |
                (mcs_r[`MTS_MC_WRTHR:`MTS_MC_RDTHR]
                 & ~(wr_mcs && WB_SEL_I[2] ? WB_DAT_I[`MTS_MC_WRTHR:`MTS_MC_RDTHR] : 2'b00));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control outputs.

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            DEMAND_SCRUB_ENABLE <= 1'b0;
            SCRUB_ALGORITHMS    <= 3'b000;
            WIPE_ZEROS          <= 1'b0;
        end else begin
            DEMAND_SCRUB_ENABLE <= mcs_r[`MTS_MC_DEMSCRUB];
            SCRUB_ALGORITHMS    <= {mcs_r[`MTS_MC_DSALGO], mcs_r[`MTS_MC_PSALGO],
                                    mcs_r[`MTS_MC_SPALGO]};
            WIPE_ZEROS          <= SPARING_ENABLE && copy_busy && mcs_r[`MTS_MC_WIPE];
        end
    end

    // Exactly one rank at threshold starts the fail-over.
    logic [3:0] hit_cnt;
    logic [2:0] hit_rank;
    always_comb begin
        hit_cnt  = 4'h0;
        hit_rank = 3'h0;
        for (int r = 0; r < 8; r++) begin
            if (RANK_ERROR_COUNT[r] == mcs_r[`MTS_MC_SPARE_ERROR_THRESHOLD_HI:`MTS_MC_SPARE_ERROR_THRESHOLD_LO]) begin
                hit_cnt  = hit_cnt + 4'h1;
                hit_rank = 3'(r);
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            SPARE_START       <= 1'b0;
            SPARE_FAILED_RANK <= 3'h0;
        end else begin
            SPARE_START <= SPARING_ENABLE && !copy_busy && (hit_cnt == 4'h1) && !SPARE_START;
            if (SPARING_ENABLE && !copy_busy && hit_cnt == 4'h1) begin
                SPARE_FAILED_RANK <= hit_rank;
            end
        end
    end

    // Activate throttle: 4 per 10 command clocks, or 4 per row cycle when conservative.
    localparam int WIN_AGG = `MTS_ACT_WIN_CMD * `MTS_CORE_PER_CMD;
    parameter  int TRC_CYC = 12;
    // A sliding history holds the limit over any run of cycles, not only aligned windows.
    logic [15:0] act_hist_r;
    logic [4:0]  act_cnt;
    logic [7:0]  win_len;
    assign win_len        = mcs_r[`MTS_MC_EPOL] ? 8'(TRC_CYC) : 8'(WIN_AGG);
    assign ACTIVATE_GRANT = ACTIVATE_REQ && (act_cnt < 5'(`MTS_ACT_LIMIT));

    always_comb begin
        act_cnt = 5'h0;
        for (int i = 0; i < 16; i++) begin
            if (8'(i) < win_len - 8'h1) begin
                act_cnt = act_cnt + {4'h0, act_hist_r[i]};
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            act_hist_r <= 16'h0;
        end else begin
            act_hist_r <= {act_hist_r[14:0], ACTIVATE_GRANT};
        end
    end

    // Thermal cap: per 100 us window, budget in cycles of 50% or 62.5%.
    localparam int BUD1 = CAP_CYC * `MTS_DDR1_PCT_X10 / 1000;
    localparam int BUD2 = CAP_CYC * `MTS_DDR2_PCT_X10 / 1000;
    logic [17:0] cap_tmr_r;
    logic [17:0] used_r;
    logic [17:0] budget;
    assign budget        = FIRST_GEN_DDR_SELECT ? 18'(BUD1) : 18'(BUD2);
    assign THERMAL_GRANT = !mcs_r[`MTS_MC_THERM] || (used_r < budget);

    always_ff @(posedge CORE_CLK) begin
        if (RST || cap_tmr_r == 18'(CAP_CYC - 1)) begin
            cap_tmr_r <= 18'h0;
            used_r    <= 18'h0;
        end else begin
            cap_tmr_r <= cap_tmr_r + 18'h1;
            if (issue) begin
                used_r <= used_r + 18'h1;
            end
        end
    end

endmodule // mts_engine

/* File: verilog/mts_consts.svh */
`ifndef MTS_CONSTS_SVH
`define MTS_CONSTS_SVH

// Register indices as printed; the byte address is four times the index.
`define MTS_IDX_RESULT      8'h5d
`define MTS_IDX_CTRL        8'h5e
`define MTS_IDX_MCS         8'h60
`define MTS_ADDR_W          10

// Result register fields.
`define MTS_RES_CH0         0
`define MTS_RES_CH1         1

// Test and scrub control fields.
`define MTS_CTL_EN          0
`define MTS_CTL_MODE_LO     1
`define MTS_CTL_MODE_HI     2
`define MTS_CTL_DONE        3
`define MTS_CTL_PAT_LO      4
`define MTS_CTL_PAT_HI      5

// Memory control settings fields.
`define MTS_MC_RANK_LO      0
`define MTS_MC_RANK_HI      2
`define MTS_MC_SPARE_LO     3
`define MTS_MC_SPARE_HI     5
`define MTS_MC_WIPE         6
`define MTS_MC_THERM        7
`define MTS_MC_SINGLE       8
`define MTS_MC_SPALGO       11
`define MTS_MC_PSALGO       12
`define MTS_MC_DSALGO       13
`define MTS_MC_DEMSCRUB     14
`define MTS_MC_SPARE_ERROR_THRESHOLD_LO      16
`define MTS_MC_SPARE_ERROR_THRESHOLD_HI      19
`define MTS_MC_EPOL         20
`define MTS_MC_RDTHR        21
`define MTS_MC_WRTHR        22
`define MTS_MC_RW_MASK      32'h001f79c7

// Timing.
`define MTS_PATROL_CYC      16384
`define MTS_CLK_MHZ         200
`define MTS_CAP_US          100
`define MTS_CAP_CYC         (`MTS_CAP_US * `MTS_CLK_MHZ)
`define MTS_DDR1_PCT_X10    500
`define MTS_DDR2_PCT_X10    625
`define MTS_ACT_LIMIT       4
`define MTS_ACT_WIN_CMD     10
`define MTS_CORE_PER_CMD    1

`endif

/* File: verilog/mts_pkg.sv */
package mts_pkg;
    typedef enum logic [1:0] {
        MTS_MODE_FWRITE,
        MTS_MODE_RSVD,
        MTS_MODE_PATROL,
        MTS_MODE_FVERIFY
    } mts_mode_t;

    typedef enum logic [1:0] {
        MTS_PAT_ZERO,
        MTS_PAT_RAND,
        MTS_PAT_INV,
        MTS_PAT_RSVD
    } mts_pat_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [2:0]  rank;
        logic [31:0] addr;
        logic [63:0] data;
    } mts_mem_req_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  mismatch;
    } mts_mem_rsp_t;
endpackage

/* File: dv/mts_engine_asserts.sv */
`include "mts_consts.svh"

module mts_engine_asserts
    import mts_pkg::*;
(
    input wire logic                   CORE_CLK,
    input wire logic                   RST,
    input wire logic [`MTS_ADDR_W-1:0] WB_ADR_I,
    input wire logic                   WB_STB_I,
    input wire logic                   WB_CYC_I,
    input wire logic                   WB_ACK_O,
    input wire logic                   WB_ERR_O,
    input wire mts_pkg::mts_mem_req_t  MEM_REQ,
    input wire logic                   MEM_READY,
    input wire logic                   ACTIVATE_REQ,
    input wire logic                   ACTIVATE_GRANT,
    input wire logic                   SPARING_ENABLE,
    input wire logic                   SPARE_START
);
    logic       mapped;
    logic [9:0] act_hist_r;
    assign mapped = WB_ADR_I[9:2] inside {`MTS_IDX_RESULT, `MTS_IDX_CTRL, `MTS_IDX_MCS};
    // Both policies allow at most four activates in any ten cycles, so one window serves both.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            act_hist_r <= '0;
        end else begin
            act_hist_r <= {act_hist_r[8:0], ACTIVATE_REQ & ACTIVATE_GRANT};
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////////
    ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
    ack_timing_a: assert property ($rose(WB_STB_I) && WB_CYC_I && mapped |=> WB_ACK_O && !WB_ERR_O)
        else $error("mapped access not acked");
    err_unmapped_a: assert property ($rose(WB_STB_I) && WB_CYC_I && !mapped |=> WB_ERR_O && !WB_ACK_O)
        else $error("unmapped access not refused");
    answer_cause_a: assert property ((WB_ACK_O || WB_ERR_O) |-> $past(WB_STB_I && WB_CYC_I))
        else $error("answer without request");
    req_ready_a: assert property (MEM_REQ.valid |-> $past(MEM_READY)) else $error("access while not ready");
    act_window_a: assert property ($countones({act_hist_r[8:0], ACTIVATE_REQ & ACTIVATE_GRANT}) <= 4)
        else $error("too many activates in window");
    spare_pulse_a: assert property (SPARE_START |=> !SPARE_START) else $error("spare start too long");
    spare_cause_a: assert property (SPARE_START |-> $past(SPARING_ENABLE)) else $error("spare without enable");
    cover property (MEM_REQ.valid && MEM_REQ.write);
    cover property (MEM_REQ.valid && !MEM_REQ.write);
    cover property (WB_ERR_O);
    cover property (SPARE_START);
endmodule // mts_engine_asserts

/* File: dv/mts_mem_model.sv */
module mts_mem_model
    import mts_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         clr,
    input  wire mts_mem_req_t req,
    input  wire logic         slow,
    input  wire logic [1:0]   inj,
    output logic              ready,
    output mts_mem_rsp_t      rsp,
    output logic              flushed,
    output int                wr_n,
    output int                rd_n,
    output logic [63:0]       data_or,
    output logic [31:0]       last_addr,
    output logic [2:0]        last_rank
);
    logic [15:0] stall_r;
    logic [1:0]  pend_r;
    // A slow memory refuses on about half the cycles, so the engine must really wait.
    assign ready = !slow || stall_r[0];
    assign flushed = (pend_r == 2'h0) && !req.valid;
    always_ff @(posedge clk) begin
        stall_r <= {stall_r[14:0], stall_r[15] ^ stall_r[13] ^ stall_r[12] ^ stall_r[10]};
        rsp.valid <= req.valid && !req.write;
        rsp.mismatch <= (req.valid && !req.write) ? inj : 2'h0;
        pend_r <= (req.valid && req.write) ? 2'h3 : pend_r - (pend_r != 2'h0);
        if (rst || clr) begin
            wr_n <= 0;
            rd_n <= 0;
            data_or <= '0;
        end else if (req.valid) begin
            wr_n <= wr_n + req.write;
            rd_n <= rd_n + !req.write;
            data_or <= data_or | (req.write ? req.data : 64'h0);
            last_addr <= req.addr;
            last_rank <= req.rank;
        end
    end
endmodule // mts_mem_model

/* File: dv/tb.sv */
`include "mts_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mts_pkg::*;
    logic            CORE_CLK = 0, RST = 1, we = 0, stb = 0, cyc = 0, ack, err, last_err;
    logic [9:0]      adr = '0;
    logic [31:0]     wdat = '0, rdat, rec_addr = '0, q, mc_val, seed = 32'h9c68ff72, seed2 = 32'h9c68ff72;
    logic            rd_thr = 0, wr_thr = 0, act_req = 0, ddr1 = 0, spar = 0, busy = 0, csr = 0, slow = 0, clr = 0;
    logic [1:0]      inj = '0;
    logic [7:0][3:0] cnt = '0;
    mts_mem_req_t    req;
    mts_mem_rsp_t    rsp;
    logic            ready, flushed, act_gnt, th_gnt, sp_start, wipe, dem;
    logic [2:0]      sp_rank, algos, last_rank;
    logic [63:0]     data_or;
    logic [31:0]     last_addr;
    int              wr_n, rd_n, n, bad_count = 0, comparisons = 0, starts = 0;
    logic [7:0]      ids [4] = '{8'h5d, 8'h5e, 8'h60, 8'h61};
    logic [31:0]     bad_cmds [3] = '{32'h3, 32'h31, 32'h37};

    mts_engine #(.ADDR_W(4), .PATROL_CYC(16), .CAP_CYC(100)) mts_engine_inst (
        .CORE_CLK(CORE_CLK), .RST(RST), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_WE_I(we),
        .WB_SEL_I(4'hf), .WB_STB_I(stb), .WB_CYC_I(cyc), .WB_ACK_O(ack), .WB_ERR_O(err), .MEM_REQ(req),
        .MEM_READY(ready), .MEM_RSP(rsp), .MEM_WR_FLUSHED(flushed), .RECORDED_ERROR_ADDR(rec_addr),
        .RD_THROTTLED(rd_thr), .WR_THROTTLED(wr_thr), .ACTIVATE_REQ(act_req), .FIRST_GEN_DDR_SELECT(ddr1),
        .SPARING_ENABLE(spar), .RANK_ERROR_COUNT(cnt), .SPARE_COPY_BUSY(busy), .CONFIG_SAVE_RESTORE(csr),
        .ACTIVATE_GRANT(act_gnt), .THERMAL_GRANT(th_gnt), .SPARE_START(sp_start), .SPARE_FAILED_RANK(sp_rank),
        .WIPE_ZEROS(wipe), .DEMAND_SCRUB_ENABLE(dem), .SCRUB_ALGORITHMS(algos));
    mts_mem_model mts_mem_model_inst (.clk(CORE_CLK), .rst(RST), .clr(clr), .req(req), .slow(slow), .inj(inj),
        .ready(ready), .rsp(rsp), .flushed(flushed), .wr_n(wr_n), .rd_n(rd_n), .data_or(data_or),
        .last_addr(last_addr), .last_rank(last_rank));

    function automatic logic [31:0] rnd(inout logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end
    // Background traffic keeps the activate limiter and the cap selector busy all run long.
    always @(posedge CORE_CLK) begin
        act_req <= rnd(seed2) > 32'h60000000;
        ddr1 <= seed2[7];
        if (sp_start === 1'b1) starts++;
    end
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wb(input logic [7:0] idx, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        adr <= {idx, 2'b00};
        we <= w;
        wdat <= d;
        stb <= 1'b1;
        cyc <= 1'b1;
        do begin @(posedge CORE_CLK); k++; end while (ack !== 1'b1 && err !== 1'b1 && k < 40);
        q = rdat;
        last_err = err;
        stb <= 1'b0;
        cyc <= 1'b0;
        if (k >= 40) begin bad_count++; print_verdict(); end
        @(posedge CORE_CLK);
    endtask
    task automatic clear_model();
        clr <= 1'b1;
        @(posedge CORE_CLK);
        clr <= 1'b0;
    endtask
    // Runs one fast or patrol command to its first completion, then turns the engine off again unless it is a patrol command.
    task automatic run_cmd(input logic [31:0] cmd);
        int k;
        clear_model();
        wb(8'h5e, 1, cmd);
        k = 0;
        do begin wb(8'h5e, 0, 0); k++; end while (q[3] !== 1'b1 && k < 300);
        if (k >= 300) begin bad_count++; print_verdict(); end
        `CHK(q, cmd | 32'h8)
        if (cmd[2:1] != 2'b10) wb(8'h5e, 1, 32'h8);
    endtask
    initial begin
        repeat (12) @(posedge CORE_CLK);
        RST <= 1'b0;
        @(posedge CORE_CLK);
        for (int i = 0; i < 4; i++) begin
            wb(ids[i], 0, 0);
            `CHK(q, 32'h0)
            `CHK(last_err, i == 3)
        end
        $display("reset values done");
        for (int p = 0; p < 3; p++) begin
            mc_val = rnd(seed) & 32'h7;
            slow <= seed[9];
            wb(8'h60, 1, mc_val);
            run_cmd(32'h1 | (p << 4));
            `CHK(wr_n, 16)
            `CHK(last_rank, mc_val[2:0])
            `CHK(data_or == 64'h0, p == 0)
        end
        $display("fast write done");
        for (int m = 0; m < 4; m++) begin
            inj <= m[1:0];
            run_cmd(32'h7);
            `CHK(rd_n, 16)
            wb(8'h5d, 0, 0);
            `CHK(q, {30'h0, m[1:0]})
            wb(8'h5d, 1, 32'h3);
            wb(8'h5d, 0, 0);
            `CHK(q, 32'h0)
        end
        $display("fast verify done");
        rec_addr <= rnd(seed);
        wb(8'h60, 1, 32'h100);
        run_cmd(32'h11);
        `CHK(wr_n, 1)
        `CHK(last_addr, rec_addr)
        $display("single address done");
        for (int i = 0; i < 3; i++) begin
            clear_model();
            wb(8'h5e, 1, bad_cmds[i]);
            repeat (40) @(posedge CORE_CLK);
            wb(8'h5e, 0, 0);
            `CHK(q, bad_cmds[i])
            `CHK(wr_n + rd_n, 0)
            wb(8'h5e, 1, 0);
        end
        $display("reserved codes done");
        slow <= 1'b0;
        wb(8'h60, 1, 0);
        run_cmd(32'h5);
        clear_model();
        repeat (64) @(posedge CORE_CLK);
        `CHK(wr_n + rd_n >= 3 && wr_n + rd_n <= 5, 1)
        wb(8'h5e, 1, 32'h8);
        clear_model();
        repeat (40) @(posedge CORE_CLK);
        `CHK(wr_n + rd_n, 0)
        csr <= 1'b1;
        wb(8'h5e, 1, 32'h5);
        wb(8'h5e, 0, 0);
        `CHK(q, 32'h4)
        csr <= 1'b0;
        wb(8'h5e, 1, 0);
        $display("patrol done");
        spar <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            mc_val = rnd(seed) & `MTS_MC_RW_MASK;
            wb(8'h60, 1, mc_val);
            wb(8'h60, 0, 0);
            `CHK(q, mc_val)
            `CHK(dem, mc_val[14])
            `CHK(algos, mc_val[13:11])
            `CHK(wipe, 1'b0)
        end
        busy <= 1'b1;
        wb(8'h60, 1, mc_val ^ 32'h38);
        wb(8'h60, 0, 0);
        `CHK(q, mc_val)
        `CHK(wipe, mc_val[6])
        busy <= 1'b0;
        rd_thr <= 1'b1;
        @(posedge CORE_CLK);
        rd_thr <= 1'b0;
        wr_thr <= 1'b1;
        @(posedge CORE_CLK);
        wr_thr <= 1'b0;
        wb(8'h60, 0, 0);
        `CHK(q, mc_val | 32'h600000)
        wb(8'h60, 1, mc_val | 32'h600000);
        wb(8'h60, 0, 0);
        `CHK(q, mc_val)
        $display("control settings done");
        wb(8'h60, 1, 32'h30000);
        cnt[5] <= 4'h3;
        cnt[2] <= 4'h3;
        repeat (20) @(posedge CORE_CLK);
        `CHK(starts, 0)
        cnt[2] <= 4'h0;
        repeat (20) @(posedge CORE_CLK);
        `CHK(starts > 0, 1)
        `CHK(sp_rank, 3'h5)
        $display("spare fail-over done");
        print_verdict();
    end
endmodule // tb

bind mts_engine mts_engine_asserts mts_engine_asserts_inst (.CORE_CLK(CORE_CLK), .RST(RST), .WB_ADR_I(WB_ADR_I),
    .WB_STB_I(WB_STB_I), .WB_CYC_I(WB_CYC_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .MEM_REQ(MEM_REQ),
    .MEM_READY(MEM_READY), .ACTIVATE_REQ(ACTIVATE_REQ), .ACTIVATE_GRANT(ACTIVATE_GRANT),
    .SPARING_ENABLE(SPARING_ENABLE), .SPARE_START(SPARE_START));
